// ---- logic/hcsl_map.vh ----
`ifndef HCSL_MAP_VH
`define HCSL_MAP_VH
// Contract
// R01: Heat/cool only when cooling output assigned
// R02: Cooling band equals heating band times coefficient
// R03: Coefficient used only heat/cool, 2-PID, not independent
// R04: Dead band centred on target setpoint
// R05: Negative dead band means overlap band
// R06: Manual reset added when standard 2-PID, I=0
// R07: Independent method codes 0 off,1 air,2 water,3 linear
// R08: Independent mode uses banked cooling constants
// R09: Auto tuning writes cooling constants when independent
// R10: Decimal position 0 treated as 1
// R11: Banked target setpoint -1999 to 9999, default 0
// R12: Internal setpoint clamped to input and limiter range
// R13: Upper and lower limits, defaults 9999 and -1999
// R14: Larger limit acts as upper when swapped
// R15: Limits clamped to input range first
// R16: Stored setpoint never modified, only internal copy
// R17: Output mode 0 standard, 1 heating/cooling
// R18: Tenths held as signed integers scaled by ten

// Register offsets
`define HCSL_A_CTRL      8'h00
`define HCSL_A_IN_LO     8'h04
`define HCSL_A_IN_HI     8'h08
`define HCSL_A_SP_HI     8'h0C
`define HCSL_A_SP_LO     8'h10
`define HCSL_A_ISP       8'h14
`define HCSL_A_COOL_PB   8'h18
`define HCSL_A_STAT      8'h1C
// Bank window: address bit 7 set, bank in [6:5], field in [4:2]
`define HCSL_BANK_BIT    7

// Control register fields
`define HCSL_C_OUT_MODE  0
`define HCSL_C_COOL_ASG  1
`define HCSL_C_PID       2
`define HCSL_C_INDEP_LO  3
`define HCSL_C_BANK_LO   5
`define HCSL_C_DEC_LO    8
`define HCSL_CTRL_RST    16'h0004

// Status register fields
`define HCSL_S_HC        0
`define HCSL_S_COEF      1
`define HCSL_S_INDEP     2
`define HCSL_S_MRST      3
`define HCSL_S_OVERLAP   4
`define HCSL_S_INIT      5

// Encodings
`define HCSL_MODE_STD    1'b0
`define HCSL_MODE_HC     1'b1
`define HCSL_IND_OFF     2'h0
`define HCSL_IND_AIR     2'h1
`define HCSL_IND_WATER   2'h2
`define HCSL_IND_LINEAR  2'h3

// Bank fields
`define HCSL_F_SP        3'h0
`define HCSL_F_COEF      3'h1
`define HCSL_F_DB        3'h2
`define HCSL_F_MRST      3'h3
`define HCSL_F_CPB       3'h4
`define HCSL_F_CIT       3'h5
`define HCSL_F_CDT       3'h6

// Reset values and ranges, tenths or hundredths as integers
`define HCSL_SP_RST      16'h0000
`define HCSL_COEF_RST    16'h0064
`define HCSL_DB_RST      16'h0000
`define HCSL_MRST_RST    16'h01F4
`define HCSL_CPB_RST     16'h0050
`define HCSL_CIT_RST     16'h00E9
`define HCSL_CDT_RST     16'h0190
`define HCSL_LIM_HI_RST  16'h270F
`define HCSL_LIM_LO_RST  16'hF831
`define HCSL_V_MAX       16'h270F
`define HCSL_V_MIN       16'hF831
`define HCSL_COEF_MIN    16'h0001
`define HCSL_MRST_MAX    16'h03E8
`define HCSL_CIT_MAX     16'h0F9F
`define HCSL_COEF_DIV    32'h00000064
`endif

// ---- logic/hcsl_bank_mem.v ----
`timescale 1ns/1ns
// Banked parameter store, one write and one registered read port
module hcsl_bank_mem #(
	parameter DW = 16,
	parameter AW = 5
)(
	// Clock
	input  wire          i_clk,
	// Write port
	input  wire          i_we,
	input  wire [AW-1:0] i_waddr,
	input  wire [DW-1:0] i_wdata,
	// Read port
	input  wire [AW-1:0] i_raddr,
	output reg  [DW-1:0] o_rdata
);
	reg [DW-1:0] mem [0:(1<<AW)-1];  // No reset; the owner sweeps defaults in

	// Write then registered read; a same-address read returns the old word
	always @(posedge i_clk)
	begin
		if (i_we)
			mem[i_waddr] <= i_wdata;
		o_rdata <= mem[i_raddr];
	end
endmodule

// ---- logic/hcsl_limiter.v ----
`timescale 1ns/1ns
`include "hcsl_map.vh"
// Heat/cool band and setpoint limiter for one channel
module hcsl_limiter (
	// Clock and reset
	input  wire        I_CLOCK,
	input  wire        I_RST,
	// Register port
	input  wire [7:0]  I_ADDR,
	input  wire [15:0] I_WDATA,
	input  wire        I_WR,
	input  wire        I_RD,
	output wire [15:0] O_RDATA,
	// Heating side constants from the PID core, tenths
	input  wire [15:0] I_HEAT_PB,
	input  wire [15:0] I_HEAT_IT,
	// Auto tuning result for the cooling side
	input  wire        I_AT_DONE,
	input  wire [15:0] I_AT_COOL_PB,
	input  wire [15:0] I_AT_COOL_IT,
	input  wire [15:0] I_AT_COOL_DT,
	// Results towards the PID core
	output reg         O_HC_ACTIVE,
	output reg  [15:0] O_INTERNAL_SP,
	output reg  [15:0] O_COOL_PB,
	output reg  [15:0] O_COOL_IT,
	output reg  [15:0] O_COOL_DT,
	output reg  [15:0] O_HEAT_EDGE,
	output reg  [15:0] O_COOL_EDGE,
	output reg         O_OVERLAP,
	output reg         O_MRESET_EN,
	output reg  [15:0] O_MRESET_MV,
	output reg  [1:0]  O_FRAC_DIGITS
);
	// Signed helpers
	function [15:0] smax;
		input [15:0] a;
		input [15:0] b;
		smax = ($signed(a) > $signed(b)) ? a : b;
	endfunction

	function [15:0] smin;
		input [15:0] a;
		input [15:0] b;
		smin = ($signed(a) < $signed(b)) ? a : b;
	endfunction

	function [15:0] clamp;
		input [15:0] v;
		input [15:0] lo;
		input [15:0] hi;
		clamp = smin(smax(v, lo), hi);
	endfunction

	// Legal low bound of a bank field
	function [15:0] fld_lo;
		input [2:0] f;
		case (f)
			`HCSL_F_COEF: fld_lo = `HCSL_COEF_MIN;
			`HCSL_F_CPB:  fld_lo = 16'h0001;
			`HCSL_F_MRST: fld_lo = 16'h0000;
			`HCSL_F_CIT:  fld_lo = 16'h0000;
			`HCSL_F_CDT:  fld_lo = 16'h0000;
			default:      fld_lo = `HCSL_V_MIN;
		endcase
	endfunction

	// Legal high bound of a bank field
	function [15:0] fld_hi;
		input [2:0] f;
		case (f)
			`HCSL_F_MRST: fld_hi = `HCSL_MRST_MAX;
			`HCSL_F_CIT:  fld_hi = `HCSL_CIT_MAX;
			default:      fld_hi = `HCSL_V_MAX;
		endcase
	endfunction

	// Value a field takes after reset
	function [15:0] fld_rst;
		input [2:0] f;
		case (f)
			`HCSL_F_SP:   fld_rst = `HCSL_SP_RST;     // R11
			`HCSL_F_COEF: fld_rst = `HCSL_COEF_RST;   // R02
			`HCSL_F_DB:   fld_rst = `HCSL_DB_RST;     // R04
			`HCSL_F_MRST: fld_rst = `HCSL_MRST_RST;   // R06
			`HCSL_F_CPB:  fld_rst = `HCSL_CPB_RST;    // R08
			`HCSL_F_CIT:  fld_rst = `HCSL_CIT_RST;    // R08
			`HCSL_F_CDT:  fld_rst = `HCSL_CDT_RST;    // R08
			default:      fld_rst = 16'h0000;
		endcase
	endfunction

	// Address decode shared by read and write paths
	function is_bank;
		input [7:0] a;
		is_bank = a[`HCSL_BANK_BIT];
	endfunction

	// Channel registers
	reg  [15:0] ctrl_r;        // Mode, assignment, method, bank, decimals
	reg  [15:0] in_lo_r;       // Input range of the sensor
	reg  [15:0] in_hi_r;
	reg  [15:0] lim_hi_r;      // Limiter as written, clamped to -1999..9999, never altered
	reg  [15:0] lim_lo_r;
	reg  [15:0] rdata_r;       // Read data of plain registers
	reg         rd_bank_r;     // Last read went to the bank store

	// Working copies of the active bank
	reg  [15:0] w_sp_r;
	reg  [15:0] w_coef_r;
	reg  [15:0] w_db_r;
	reg  [15:0] w_mrst_r;
	reg  [15:0] w_cpb_r;
	reg  [15:0] w_cit_r;
	reg  [15:0] w_cdt_r;

	// Init sweep, refresh sequencer, auto tuning writeback
	reg         init_r;        // Defaults being swept into the store
	reg  [4:0]  init_idx_r;
	reg  [2:0]  seq_f_r;       // Field being refreshed
	reg  [2:0]  ret_f_r;       // Field whose word returns now
	reg         ret_v_r;       // A refresh word returns now
	reg  [2:0]  at_pend_r;     // Cooling PB, IT, DT still to store
	reg  [15:0] at_pb_r;
	reg  [15:0] at_it_r;
	reg  [15:0] at_dt_r;

	// Decoded control fields
	wire        out_hc    = ctrl_r[`HCSL_C_OUT_MODE] == `HCSL_MODE_HC;  // R17
	wire        cool_asg  = ctrl_r[`HCSL_C_COOL_ASG];
	wire        pid2      = ctrl_r[`HCSL_C_PID];
	wire [1:0]  indep     = ctrl_r[`HCSL_C_INDEP_LO+1:`HCSL_C_INDEP_LO];
	wire [1:0]  bank      = ctrl_r[`HCSL_C_BANK_LO+1:`HCSL_C_BANK_LO];
	wire [1:0]  dec_pos   = ctrl_r[`HCSL_C_DEC_LO+1:`HCSL_C_DEC_LO];
	// Heat/cool needs both the mode and a cooling output to drive
	wire        hc_act    = out_hc & cool_asg;                        // R01
	wire        ind_act   = hc_act & pid2 & (indep != `HCSL_IND_OFF); // R07
	wire        coef_act  = hc_act & pid2 & (indep == `HCSL_IND_OFF); // R03
	wire        mrst_act  = ~out_hc & pid2 & (I_HEAT_IT == 16'h0000); // R06

	// Bank store ports
	wire        host_bw   = I_WR & is_bank(I_ADDR) & ~init_r;
	wire        host_br   = I_RD & is_bank(I_ADDR);
	wire [2:0]  host_f    = I_ADDR[4:2];
	reg         mem_we;
	reg  [4:0]  mem_wa;
	reg  [15:0] mem_wd;
	reg  [2:0]  at_clr;
	wire [4:0]  mem_ra    = host_br ? I_ADDR[6:2] : {bank, seq_f_r};
	wire [15:0] mem_rd;

	// Write arbitration: sweep first, then host, then tuning results
	always @*
	begin
		mem_we = 1'b0;
		mem_wa = 5'h00;
		mem_wd = 16'h0000;
		at_clr = 3'h0;
		if (init_r)
		begin
			mem_we = 1'b1;
			mem_wa = init_idx_r;
			mem_wd = fld_rst(init_idx_r[2:0]);
		end
		else if (host_bw)
		begin
			// Out of range values are pulled to the field limits
			mem_we = 1'b1;
			mem_wa = I_ADDR[6:2];
			mem_wd = clamp(I_WDATA, fld_lo(host_f), fld_hi(host_f));
		end
		else if (at_pend_r[0])
		begin
			mem_we = 1'b1;                                      // R09
			mem_wa = {bank, `HCSL_F_CPB};
			mem_wd = clamp(at_pb_r, 16'h0001, `HCSL_V_MAX);
			at_clr = 3'h1;
		end
		else if (at_pend_r[1])
		begin
			mem_we = 1'b1;                                      // R09
			mem_wa = {bank, `HCSL_F_CIT};
			mem_wd = clamp(at_it_r, 16'h0000, `HCSL_CIT_MAX);
			at_clr = 3'h2;
		end
		else if (at_pend_r[2])
		begin
			mem_we = 1'b1;                                      // R09
			mem_wa = {bank, `HCSL_F_CDT};
			mem_wd = clamp(at_dt_r, 16'h0000, `HCSL_V_MAX);
			at_clr = 3'h4;
		end
	end

	hcsl_bank_mem #(
		.DW (16),
		.AW (5)
	) i_hcsl_bank_mem (
		.i_clk   (I_CLOCK),
		.i_we    (mem_we),
		.i_waddr (mem_wa),
		.i_wdata (mem_wd),
		.i_raddr (mem_ra),
		.o_rdata (mem_rd)
	);

	// Plain register writes and read capture
	always @(posedge I_CLOCK or posedge I_RST)
	begin
		if (I_RST)
		begin
			ctrl_r    <= `HCSL_CTRL_RST;
			in_lo_r   <= `HCSL_LIM_LO_RST;
			in_hi_r   <= `HCSL_LIM_HI_RST;
			lim_hi_r  <= `HCSL_LIM_HI_RST;                      // R13
			lim_lo_r  <= `HCSL_LIM_LO_RST;                      // R13
			rdata_r   <= 16'h0000;
			rd_bank_r <= 1'b0;
		end
		else
		begin
			if (I_WR)
			begin
				case (I_ADDR)
					`HCSL_A_CTRL:  ctrl_r   <= I_WDATA;
					`HCSL_A_IN_LO: in_lo_r  <= clamp(I_WDATA, `HCSL_V_MIN, `HCSL_V_MAX);
					`HCSL_A_IN_HI: in_hi_r  <= clamp(I_WDATA, `HCSL_V_MIN, `HCSL_V_MAX);
					`HCSL_A_SP_HI: lim_hi_r <= clamp(I_WDATA, `HCSL_V_MIN, `HCSL_V_MAX);
					`HCSL_A_SP_LO: lim_lo_r <= clamp(I_WDATA, `HCSL_V_MIN, `HCSL_V_MAX);
					default:       ctrl_r   <= ctrl_r;
				endcase
			end
			// Read data stands in the cycle after the strobe only
			rd_bank_r <= host_br;
			rdata_r   <= 16'h0000;
			if (I_RD)
			begin
				case (I_ADDR)
					`HCSL_A_CTRL:    rdata_r <= ctrl_r;
					`HCSL_A_IN_LO:   rdata_r <= in_lo_r;
					`HCSL_A_IN_HI:   rdata_r <= in_hi_r;
					`HCSL_A_SP_HI:   rdata_r <= lim_hi_r;
					`HCSL_A_SP_LO:   rdata_r <= lim_lo_r;
					`HCSL_A_ISP:     rdata_r <= O_INTERNAL_SP;
					`HCSL_A_COOL_PB: rdata_r <= O_COOL_PB;
					`HCSL_A_STAT:    rdata_r <= {10'h000, init_r, O_OVERLAP,
						O_MRESET_EN, ind_act, coef_act, O_HC_ACTIVE};
					default:         rdata_r <= 16'h0000;
				endcase
			end
		end
	end

	// Both sources are flip-flops; the mux only selects
	assign O_RDATA = rd_bank_r ? mem_rd : rdata_r;

	// Default sweep, then a rolling refresh of the active bank
	always @(posedge I_CLOCK or posedge I_RST)
	begin
		if (I_RST)
		begin
			init_r     <= 1'b1;
			init_idx_r <= 5'h00;
			seq_f_r    <= 3'h0;
			ret_f_r    <= 3'h0;
			ret_v_r    <= 1'b0;
		end
		else
		begin
			if (init_r)
			begin
				init_idx_r <= init_idx_r + 5'h01;
				if (init_idx_r == 5'h1F)
					init_r <= 1'b0;
			end
			// A host read steals the port; the refresh waits a cycle
			ret_v_r <= ~host_br & ~init_r;
			ret_f_r <= seq_f_r;
			if (~host_br & ~init_r)
				seq_f_r <= (seq_f_r == `HCSL_F_CDT) ? 3'h0 : seq_f_r + 3'h1;
		end
	end

	// Tuning results queue; a new result sets over a clear
	always @(posedge I_CLOCK or posedge I_RST)
	begin
		if (I_RST)
		begin
			at_pend_r <= 3'h0;
			at_pb_r   <= 16'h0000;
			at_it_r   <= 16'h0000;
			at_dt_r   <= 16'h0000;
		end
		else if (I_AT_DONE & ind_act)
		begin
			at_pend_r <= 3'h7;                                  // R09
			at_pb_r   <= I_AT_COOL_PB;
			at_it_r   <= I_AT_COOL_IT;
			at_dt_r   <= I_AT_COOL_DT;
		end
		else
			at_pend_r <= at_pend_r & ~at_clr;
	end

	// Working copies follow the store, which keeps the banked values
	always @(posedge I_CLOCK or posedge I_RST)
	begin
		if (I_RST)
		begin
			w_sp_r   <= `HCSL_SP_RST;
			w_coef_r <= `HCSL_COEF_RST;
			w_db_r   <= `HCSL_DB_RST;
			w_mrst_r <= `HCSL_MRST_RST;
			w_cpb_r  <= `HCSL_CPB_RST;
			w_cit_r  <= `HCSL_CIT_RST;
			w_cdt_r  <= `HCSL_CDT_RST;
		end
		else if (ret_v_r)
		begin
			case (ret_f_r)
				`HCSL_F_SP:   w_sp_r   <= mem_rd;                   // R11
				`HCSL_F_COEF: w_coef_r <= mem_rd;
				`HCSL_F_DB:   w_db_r   <= mem_rd;
				`HCSL_F_MRST: w_mrst_r <= mem_rd;
				`HCSL_F_CPB:  w_cpb_r  <= mem_rd;                   // R08
				`HCSL_F_CIT:  w_cit_r  <= mem_rd;
				`HCSL_F_CDT:  w_cdt_r  <= mem_rd;
				default:      w_sp_r   <= w_sp_r;
			endcase
		end
	end

	// Limiter, all compares on signed tenths-scaled integers
	wire [15:0] lim_top  = smax(lim_hi_r, lim_lo_r);                // R14
	wire [15:0] lim_bot  = smin(lim_hi_r, lim_lo_r);
	wire [15:0] in_top   = smax(in_hi_r, in_lo_r);
	wire [15:0] in_bot   = smin(in_hi_r, in_lo_r);
	wire [15:0] eff_hi   = clamp(lim_top, in_bot, in_top);          // R15
	wire [15:0] eff_lo   = clamp(lim_bot, in_bot, in_top);          // R15
	// Only the internal copy is clamped; the banked setpoint stays
	wire [15:0] isp      = clamp(w_sp_r, eff_lo, eff_hi);           // R12 R16 R18

	// Cooling band from heating band and coefficient in hundredths
	wire [31:0] prod     = {16'h0000, I_HEAT_PB} * {16'h0000, w_coef_r};
	wire [31:0] quot     = prod / `HCSL_COEF_DIV;                   // R02
	wire [15:0] scaled   = (quot > {16'h0000, `HCSL_V_MAX}) ? `HCSL_V_MAX : quot[15:0];
	// Dead band split evenly either side of the setpoint
	// Signed shift so a negative band keeps its sign in the top bit
	wire [16:0] half     = $signed({w_db_r[15], w_db_r}) >>> 1;
	wire [16:0] isp_x    = {isp[15], isp};
	wire [16:0] h_edge   = isp_x - half;                            // R04
	wire [16:0] c_edge   = isp_x + half;                            // R04
	// A 17-bit edge cannot leave 16 bits for legal inputs
	wire [15:0] h_edge_s = h_edge[15:0];
	wire [15:0] c_edge_s = c_edge[15:0];

	// Registered results towards the control core
	always @(posedge I_CLOCK or posedge I_RST)
	begin
		if (I_RST)
		begin
			O_HC_ACTIVE   <= 1'b0;
			O_INTERNAL_SP <= 16'h0000;
			O_COOL_PB     <= 16'h0000;
			O_COOL_IT     <= 16'h0000;
			O_COOL_DT     <= 16'h0000;
			O_HEAT_EDGE   <= 16'h0000;
			O_COOL_EDGE   <= 16'h0000;
			O_OVERLAP     <= 1'b0;
			O_MRESET_EN   <= 1'b0;
			O_MRESET_MV   <= 16'h0000;
			O_FRAC_DIGITS <= 2'h1;
		end
		else
		begin
			O_HC_ACTIVE   <= hc_act;                                // R01
			O_INTERNAL_SP <= isp;                                   // R12
			// Independent set replaces the coefficient path outright
			if (ind_act)
			begin
				O_COOL_PB <= w_cpb_r;                               // R08
				O_COOL_IT <= w_cit_r;                               // R08
				O_COOL_DT <= w_cdt_r;                               // R08
			end
			else if (coef_act)
			begin
				O_COOL_PB <= scaled;                                // R02 R03
				O_COOL_IT <= I_HEAT_IT;
				O_COOL_DT <= 16'h0000;
			end
			else
			begin
				// Not heat/cool: cooling side idle; heat/cool without 2-PID copies the heating band
				O_COOL_PB <= hc_act ? I_HEAT_PB : 16'h0000;
				O_COOL_IT <= 16'h0000;
				O_COOL_DT <= 16'h0000;
			end
			// Edges only mean something in heating/cooling mode
			O_HEAT_EDGE <= hc_act ? h_edge_s : isp;
			O_COOL_EDGE <= hc_act ? c_edge_s : isp;
			O_OVERLAP   <= hc_act & w_db_r[15];                     // R05
			O_MRESET_EN <= mrst_act;                                // R06
			O_MRESET_MV <= mrst_act ? w_mrst_r : 16'h0000;          // R06
			// Band values always keep at least one fraction digit
			O_FRAC_DIGITS <= (dec_pos == 2'h0) ? 2'h1 : dec_pos;    // R10
		end
	end
endmodule

// ---- verif/hcsl_limiter_props.sv ----
`timescale 1ns/1ns
`include "hcsl_map.vh"
// Port-level checker for the heat/cool setpoint limiter
module hcsl_props (
	// Clock and reset
	input wire        I_CLOCK,
	input wire        I_RST,
	// Register port
	input wire [7:0]  I_ADDR,
	input wire [15:0] I_WDATA,
	input wire        I_WR,
	input wire        I_RD,
	input wire [15:0] O_RDATA,
	// Heating side and tuning inputs
	input wire [15:0] I_HEAT_PB,
	input wire [15:0] I_HEAT_IT,
	input wire        I_AT_DONE,
	input wire [15:0] I_AT_COOL_PB,
	input wire [15:0] I_AT_COOL_IT,
	input wire [15:0] I_AT_COOL_DT,
	// Results
	input wire        O_HC_ACTIVE,
	input wire [15:0] O_INTERNAL_SP,
	input wire [15:0] O_COOL_PB,
	input wire [15:0] O_COOL_IT,
	input wire [15:0] O_COOL_DT,
	input wire [15:0] O_HEAT_EDGE,
	input wire [15:0] O_COOL_EDGE,
	input wire        O_OVERLAP,
	input wire        O_MRESET_EN,
	input wire [15:0] O_MRESET_MV,
	input wire [1:0]  O_FRAC_DIGITS
);
	// Single domain, so clock and reset are given once
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (I_RST);

	// Expected clamp of a written limit value
	function automatic [15:0] lim(input [15:0] v);
		lim = ($signed(v) > $signed(`HCSL_V_MAX)) ? `HCSL_V_MAX :
			(($signed(v) < $signed(`HCSL_V_MIN)) ? `HCSL_V_MIN : v);
	endfunction

	sp_write_clamp_a: assert property (I_WR && I_ADDR == `HCSL_A_SP_HI ##1
		I_RD && I_ADDR == `HCSL_A_SP_HI |=> O_RDATA == lim($past(I_WDATA, 2)))
		else $error("Upper limit not clamped on write");
	isp_read_a: assert property (I_RD && I_ADDR == `HCSL_A_ISP ##1 $stable(O_INTERNAL_SP)
		|-> O_RDATA == O_INTERNAL_SP) else $error("Internal setpoint read differs from port");
	cpb_read_a: assert property (I_RD && I_ADDR == `HCSL_A_COOL_PB ##1 $stable(O_COOL_PB)
		|-> O_RDATA == O_COOL_PB) else $error("Cooling band read differs from port");
	isp_range_a: assert property ($signed(O_INTERNAL_SP) <= $signed(`HCSL_V_MAX) &&
		$signed(O_INTERNAL_SP) >= $signed(`HCSL_V_MIN)) else $error("Internal setpoint out of range");
	overlap_hc_a: assert property (O_OVERLAP |-> O_HC_ACTIVE)
		else $error("Overlap flagged outside heat/cool");
	overlap_edge_a: assert property (O_HC_ACTIVE |->
		O_OVERLAP == ($signed(O_COOL_EDGE) < $signed(O_HEAT_EDGE))) else $error("Overlap flag wrong");
	edge_center_a: assert property ({O_HEAT_EDGE[15], O_HEAT_EDGE} +
		{O_COOL_EDGE[15], O_COOL_EDGE} == {O_INTERNAL_SP, 1'b0}) else $error("Band not centred");
	cool_idle_a: assert property (!O_HC_ACTIVE |-> O_COOL_PB == 16'h0000 &&
		O_COOL_IT == 16'h0000 && O_COOL_DT == 16'h0000) else $error("Cooling active in standard mode");
	mreset_gate_a: assert property (O_MRESET_EN ? !O_HC_ACTIVE : O_MRESET_MV == 16'h0000)
		else $error("Manual reset gating wrong");
	frac_min_a: assert property (O_FRAC_DIGITS != 2'h0)
		else $error("Zero fractional digits");

	// Main scenarios reached
	cover property (O_OVERLAP);
	cover property (O_MRESET_EN);
	cover property (O_HC_ACTIVE && O_COOL_PB != 16'h0000);
endmodule

bind hcsl_limiter hcsl_props i_hcsl_props (.*);

// ---- verif/tb_hcsl_limiter.sv ----
`timescale 1ns/1ns
`include "hcsl_map.vh"
// Self-checking bench for the heat/cool setpoint limiter
module tb_hcsl_limiter;
	// Design inputs, all driven from time zero
	reg               I_CLOCK      = 1'b0;
	reg               I_RST        = 1'b1;
	reg        [7:0]  I_ADDR       = 8'h00;
	reg        [15:0] I_WDATA      = 16'h0000;
	reg               I_WR         = 1'b0;
	reg               I_RD         = 1'b0;
	reg        [15:0] I_HEAT_PB    = 16'h0064;
	reg        [15:0] I_HEAT_IT    = 16'h0000;
	reg               I_AT_DONE    = 1'b0;
	reg        [15:0] I_AT_COOL_PB = 16'h0000;
	reg        [15:0] I_AT_COOL_IT = 16'h0000;
	reg        [15:0] I_AT_COOL_DT = 16'h0000;
	// Design outputs
	wire       [15:0] O_RDATA, O_INTERNAL_SP, O_COOL_PB, O_COOL_IT, O_COOL_DT;
	wire       [15:0] O_HEAT_EDGE, O_COOL_EDGE, O_MRESET_MV;
	wire              O_HC_ACTIVE, O_OVERLAP, O_MRESET_EN;
	wire       [1:0]  O_FRAC_DIGITS;
	// Bench state
	integer           num_errors   = 0;
	integer           num_checks   = 0;
	integer           i, k;
	reg        [31:0] seed         = 32'd50;
	reg               rd_d         = 1'b0;
	logic      [15:0] exp_q[$];
	logic signed [15:0] sp, u, l, t, b, e;
	// Bank defaults by field index
	localparam logic [15:0] DFLT [7] = '{`HCSL_SP_RST, `HCSL_COEF_RST, `HCSL_DB_RST,
		`HCSL_MRST_RST, `HCSL_CPB_RST, `HCSL_CIT_RST, `HCSL_CDT_RST};

	hcsl_limiter i_hcsl_limiter (.*);

	// 100 MHz clock
	always #5 I_CLOCK = ~I_CLOCK;

	// Compare and count
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Random value in -1000..2999, kept inside the accepted range
	function automatic logic signed [15:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return 16'(int'(seed % 32'd4000) - 1000);
	endfunction

	function automatic logic signed [15:0] clp(input logic signed [15:0] v, lo, hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	function automatic [7:0] ba(input [1:0] bk, input [2:0] f);
		ba = {1'b1, bk, f, 2'b00};
	endfunction

	// One-cycle write, launched right after an edge
	task automatic wr(input [7:0] a, input [15:0] d);
		@(posedge I_CLOCK);
		I_WR    <= 1'b1;
		I_RD    <= 1'b0;
		I_ADDR  <= a;
		I_WDATA <= d;
	endtask

	// One-cycle read; its expectation waits in the queue
	task automatic rd(input [7:0] a, input [15:0] x);
		@(posedge I_CLOCK);
		I_WR   <= 1'b0;
		I_RD   <= 1'b1;
		I_ADDR <= a;
		exp_q.push_back(x);
	endtask

	// Drop strobes and let outputs settle past the edge
	task automatic idle(input integer n);
		@(posedge I_CLOCK);
		I_WR <= 1'b0;
		I_RD <= 1'b0;
		repeat (n) @(posedge I_CLOCK);
		#1;
	endtask

	// Read data stands only in the cycle after the strobe
	always @(posedge I_CLOCK)
	begin
		if (rd_d)
			check(O_RDATA, exp_q.pop_front());
		rd_d <= I_RD;
	end

	task print_verdict;
		$display("Checks %0d, errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Hang guard, far beyond the few hundred cycles needed
	initial
	begin
		#200000;
		num_errors++;
		print_verdict;
	end

	initial
	begin
		repeat (8) @(posedge I_CLOCK);
		I_RST <= 1'b0;
		wr(ba(2'd0, `HCSL_F_SP), 16'h0123); // Dropped by the init sweep
		idle(40);
		rd(`HCSL_A_CTRL, `HCSL_CTRL_RST);
		rd(`HCSL_A_IN_LO, `HCSL_V_MIN);
		rd(`HCSL_A_IN_HI, `HCSL_V_MAX);
		rd(`HCSL_A_SP_HI, `HCSL_LIM_HI_RST);
		rd(`HCSL_A_SP_LO, `HCSL_LIM_LO_RST);
		rd(`HCSL_A_STAT, 16'h0008);
		rd(8'h24, 16'h0000);
		for (k = 0; k < 4; k++)
			for (i = 0; i < 7; i++)
				rd(ba(k[1:0], i[2:0]), DFLT[i]);
		// Out-of-range limits written back to back with their reads
		wr(`HCSL_A_SP_HI, 16'h3000);
		rd(`HCSL_A_SP_HI, `HCSL_V_MAX);
		wr(`HCSL_A_SP_LO, 16'h8000);
		rd(`HCSL_A_SP_LO, `HCSL_V_MIN);
		idle(4);
		check(O_MRESET_EN, 1'b1);
		check(O_MRESET_MV, `HCSL_MRST_RST);
		check(O_FRAC_DIGITS, 2'h1);
		@(posedge I_CLOCK);
		I_HEAT_IT <= 16'h0010;
		idle(3);
		check(O_MRESET_EN, 1'b0);
		// Random setpoints against random, sometimes swapped, limits
		wr(`HCSL_A_IN_LO, 16'hFE0C);
		wr(`HCSL_A_IN_HI, 16'h09C4);
		for (i = 0; i < 6; i++)
		begin
			sp = rnd();
			u = rnd();
			l = rnd();
			t = clp((u > l) ? u : l, -16'sd500, 16'sd2500);
			b = clp((u > l) ? l : u, -16'sd500, 16'sd2500);
			e = clp(sp, b, t);
			wr(`HCSL_A_SP_HI, u);
			wr(`HCSL_A_SP_LO, l);
			wr(ba(2'd0, `HCSL_F_SP), sp);
			idle(16);
			check(O_INTERNAL_SP, e);
			rd(`HCSL_A_ISP, e);
			rd(ba(2'd0, `HCSL_F_SP), sp);
		end
		// Coefficient path: gated by cooling output assignment and 2-PID
		wr(ba(2'd0, `HCSL_F_COEF), 16'h00FA);
		wr(`HCSL_A_CTRL, 16'h0005);
		idle(16);
		check(O_HC_ACTIVE, 1'b0);
		wr(`HCSL_A_CTRL, 16'h0003);
		// Status mixes registered flags, so give them one edge to follow
		idle(2);
		rd(`HCSL_A_STAT, 16'h0001);
		wr(`HCSL_A_CTRL, 16'h0007);
		idle(16);
		check(O_HC_ACTIVE, 1'b1);
		check(O_COOL_PB, 16'h00FA);
		check(O_COOL_IT, 16'h0010);
		rd(`HCSL_A_COOL_PB, 16'h00FA);
		rd(`HCSL_A_STAT, 16'h0003);
		// Every independent method uses the banked cooling constants
		for (i = 1; i < 4; i++)
		begin
			wr(`HCSL_A_CTRL, 16'h0007 | (16'(i) << 3));
			idle(16);
			check(O_COOL_PB, `HCSL_CPB_RST);
			check(O_COOL_IT, `HCSL_CIT_RST);
			check(O_COOL_DT, `HCSL_CDT_RST);
			rd(`HCSL_A_STAT, 16'h0005);
		end
		// Tuning result lands in the active bank
		@(posedge I_CLOCK);
		I_RD         <= 1'b0;
		I_AT_COOL_PB <= 16'h0123;
		I_AT_COOL_IT <= 16'h0045;
		I_AT_COOL_DT <= 16'h0067;
		I_AT_DONE    <= 1'b1;
		@(posedge I_CLOCK);
		I_AT_DONE <= 1'b0;
		idle(20);
		check(O_COOL_PB, 16'h0123);
		check(O_COOL_DT, 16'h0067);
		rd(ba(2'd0, `HCSL_F_CIT), 16'h0045);
		// Negative band overlaps, positive band separates
		wr(ba(2'd0, `HCSL_F_DB), 16'hFFEC);
		idle(16);
		check(O_OVERLAP, 1'b1);
		check(O_HEAT_EDGE, e + 16'sd10);
		wr(ba(2'd0, `HCSL_F_DB), 16'h0028);
		idle(16);
		check(O_OVERLAP, 1'b0);
		check(O_COOL_EDGE, e + 16'sd20);
		// Decimal position and bank switch
		wr(ba(2'd1, `HCSL_F_SP), 16'h0064);
		wr(`HCSL_A_CTRL, 16'h023F);
		idle(16);
		check(O_FRAC_DIGITS, 2'h2);
		check(O_INTERNAL_SP, clp(16'sd100, b, t));
		// Second reset in mid-run
		@(posedge I_CLOCK);
		I_RST <= 1'b1;
		idle(2);
		check(O_INTERNAL_SP, 16'h0000);
		check(O_FRAC_DIGITS, 2'h1);
		@(posedge I_CLOCK);
		I_RST <= 1'b0;
		idle(40);
		rd(`HCSL_A_CTRL, `HCSL_CTRL_RST);
		idle(2);
		print_verdict;
	end
endmodule
